/* File: pab_pkg.sv */
// Package for the protection area base and size block.
// Shared register offsets, field positions, reset values and carrier types.
package pab_pkg;

    localparam int NUM_AREAS = 8;
    localparam int IDX_W = 3;

    // Register byte offsets on the plain register port.
    localparam logic [7:0] OFF_AREA_INDEX = 8'h00;
    localparam logic [7:0] OFF_AREA_BASE = 8'h04;
    localparam logic [7:0] OFF_ATTR_SIZE = 8'h08;
    localparam logic [7:0] OFF_CHECK_ADDR = 8'h0C;
    localparam logic [7:0] OFF_CHECK_RESULT = 8'h10;

    // Base register fields.
    localparam int BASE_UPD_BIT = 4;
    localparam int BASE_IDX_LSB = 0;
    localparam int BASE_ADDR_LSB = 5;

    // Attribute and size register fields.
    localparam int ATTR_EN_BIT = 0;
    localparam int ATTR_SIZE_LSB = 1;
    localparam int SIZE_W = 5;
    localparam logic [4:0] SIZE_FULL_MAP = 5'h1F;

    // Result register fields.
    localparam int RES_HIT_BIT = 0;
    localparam int RES_IDX_LSB = 1;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // One protection area as held by the block.
    typedef struct packed {
        logic [31:0] base;
        logic [4:0] size;
        logic enable;
    } pab_area_t;

    // Register port request.
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pab_req_t;

    // Result of an area lookup.
    typedef struct packed {
        logic hit;
        logic [2:0] idx;
    } pab_hit_t;

endpackage

/* File: pab_match.sv */
// Combinational match of one address against one protection area.
// Assumes the area fields come from registers on the same clock.
`timescale 1ns/1ns
module pab_match (
    // Area and address
    input wire pab_pkg::pab_area_t area_i,
    input wire logic [31:0] addr_i,
    // Result
    output logic hit_o
);

    // Bit N upward is compared, N being the size field plus one.
    function automatic logic [31:0] pab_mask(input logic [4:0] size);
        logic [5:0] n;
        n = {1'b0, size} + 6'h01;
        pab_mask = 32'hFFFF_FFFF << n;
    endfunction

    always_comb begin
        if (!area_i.enable) begin
            hit_o = 1'b0; // R11
        end else if (area_i.size == pab_pkg::SIZE_FULL_MAP) begin
            hit_o = 1'b1; // R2
        end else begin
            hit_o = ((addr_i ^ area_i.base) & pab_mask(area_i.size)) == 32'h0000_0000; // R3 R8
        end
    end

endmodule // pab_match

/* File: pab_top.sv */
// Protection area base and size registers with an address lookup.
// Assumes a plain register port on clk_i; read data follow the read strobe by one cycle.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// R1 - Software aligns base to area size.
// R2 - Size 31 covers whole map from zero.
// R3 - Base compared from bit size plus one.
// R4 - Flag clear: keep index, update selected base.
// R5 - Flag set: load index, update that base.
// R6 - Number-update flag reads as zero.
// R7 - Index field reads the current index.
// R8 - Area size is two to size plus one.
// R9 - Software keeps size at four or above.
// R10 - Base register follows and can change index.
// R11 - Disabled areas never match.
module pab_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Lookup result
    output logic hit_o,
    output logic [2:0] hit_idx_o
);

    ////////////////////////////////////////////////////////////////////////////////

    pab_pkg::pab_req_t req;
    pab_pkg::pab_area_t areas [pab_pkg::NUM_AREAS];
    pab_pkg::pab_area_t next_areas [pab_pkg::NUM_AREAS];
    logic [2:0] sel;
    logic [2:0] next_sel;
    logic [31:0] chk_addr;
    logic [31:0] next_chk_addr;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    pab_pkg::pab_hit_t res;
    pab_pkg::pab_hit_t next_res;
    logic [pab_pkg::NUM_AREAS-1:0] hits;

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    ////////////////////////////////////////////////////////////////////////////////

    // Aligned base bits only; the low bits of the base hold no storage.
    function automatic logic [31:0] pab_base_of(input logic [31:0] w);
        pab_base_of = {w[31:pab_pkg::BASE_ADDR_LSB], 5'h00};
    endfunction

    always_comb begin
        next_sel = sel;
        next_chk_addr = chk_addr;
        for (int i = 0; i < pab_pkg::NUM_AREAS; i++) begin
            next_areas[i] = areas[i];
        end
        if (req.wr) begin
            case (req.addr)
                pab_pkg::OFF_AREA_INDEX: begin
                    next_sel = req.wdata[2:0];
                end
                pab_pkg::OFF_AREA_BASE: begin
                    if (req.wdata[pab_pkg::BASE_UPD_BIT]) begin
                        next_sel = req.wdata[2:0]; // R5 R10
                        next_areas[req.wdata[2:0]].base = pab_base_of(req.wdata); // R5
                    end else begin
                        next_areas[sel].base = pab_base_of(req.wdata); // R4
                    end
                end
                pab_pkg::OFF_ATTR_SIZE: begin
                    next_areas[sel].enable = req.wdata[pab_pkg::ATTR_EN_BIT];
                    next_areas[sel].size = req.wdata[pab_pkg::ATTR_SIZE_LSB +: pab_pkg::SIZE_W];
                end
                pab_pkg::OFF_CHECK_ADDR: begin
                    next_chk_addr = req.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sel <= 3'h0;
            chk_addr <= pab_pkg::RESET_WORD;
            for (int i = 0; i < pab_pkg::NUM_AREAS; i++) begin
                areas[i] <= '0;
            end
        end else begin
            sel <= next_sel;
            chk_addr <= next_chk_addr;
            for (int i = 0; i < pab_pkg::NUM_AREAS; i++) begin
                areas[i] <= next_areas[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Every area is matched in parallel; the lowest index wins a tie.
    genvar g;
    generate
        for (g = 0; g < pab_pkg::NUM_AREAS; g++) begin : g_match
            pab_match u_match (
                .area_i(areas[g]),
                .addr_i(chk_addr),
                .hit_o(hits[g])
            );
        end
    endgenerate

    always_comb begin
        next_res = '0;
        for (int i = pab_pkg::NUM_AREAS - 1; i >= 0; i--) begin
            if (hits[i]) begin
                next_res.hit = 1'b1;
                next_res.idx = 3'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (req.rd) begin
            case (req.addr)
                pab_pkg::OFF_AREA_INDEX: begin
                    next_rdata = {29'h0000_0000, sel};
                end
                pab_pkg::OFF_AREA_BASE: begin
                    // Flag bit stays zero; index field shows the current index.
                    next_rdata = areas[sel].base | {29'h0000_0000, sel}; // R6 R7
                end
                pab_pkg::OFF_ATTR_SIZE: begin
                    next_rdata = {26'h000_0000, areas[sel].size, areas[sel].enable};
                end
                pab_pkg::OFF_CHECK_ADDR: begin
                    next_rdata = chk_addr;
                end
                pab_pkg::OFF_CHECK_RESULT: begin
                    next_rdata = {28'h000_0000, res.idx, res.hit};
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata <= pab_pkg::RESET_WORD;
            res <= '0;
        end else begin
            rdata <= next_rdata;
            res <= next_res;
        end
    end

    assign reg_rdata_o = rdata;
    assign hit_o = res.hit;
    assign hit_idx_o = res.idx;

    ////////////////////////////////////////////////////////////////////////////////

    a_flag_reads_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R6
        req.rd && req.addr == pab_pkg::OFF_AREA_BASE |=> !reg_rdata_o[pab_pkg::BASE_UPD_BIT])
        else $error("update flag read back as one");

    a_index_readback: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
        req.rd && req.addr == pab_pkg::OFF_AREA_BASE |=> reg_rdata_o[2:0] == $past(sel))
        else $error("index field differs from current index");

    a_keep_index: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R4
        req.wr && req.addr == pab_pkg::OFF_AREA_BASE && !req.wdata[pab_pkg::BASE_UPD_BIT]
        |=> sel == $past(sel) && areas[sel][37:11] == $past(req.wdata[31:5]))
        else $error("base write without flag moved index or lost base");

    a_load_index: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R5
        req.wr && req.addr == pab_pkg::OFF_AREA_BASE && req.wdata[pab_pkg::BASE_UPD_BIT]
        |=> sel == $past(req.wdata[2:0]) && areas[sel][37:11] == $past(req.wdata[31:5]))
        else $error("base write with flag did not load index");

    a_disabled_miss: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
        !areas[0].enable |-> !hits[0])
        else $error("disabled area matched");

    a_full_map_hit: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R2
        areas[0].enable && areas[0].size == pab_pkg::SIZE_FULL_MAP |-> hits[0])
        else $error("full map area missed");

    a_hit_result: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R8
        hits[0] |=> hit_o && hit_idx_o == 3'h0)
        else $error("area zero hit not reported");

    a_base_bit_n: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R3
        areas[0].enable && areas[0].size == 5'h04 && chk_addr[31:5] != areas[0].base[31:5]
        |-> !hits[0])
        else $error("address outside thirty two byte area matched");

    a_index_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
        req.wr && req.addr == pab_pkg::OFF_AREA_INDEX |=> sel == $past(req.wdata[2:0]))
        else $error("index write did not select area");

    a_size_readback: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R8
        req.rd && req.addr == pab_pkg::OFF_ATTR_SIZE
        |=> reg_rdata_o[pab_pkg::ATTR_SIZE_LSB +: pab_pkg::SIZE_W] == $past(areas[sel].size))
        else $error("size field read back differs from selected area");

endmodule // pab_top

/* File: pab_top_test.sv */
// Self-checking bench for the protection area base and size block.
// Assumes pab_top and pab_pkg are compiled first; the bench is the only register master.
`timescale 1ns/1ns
module pab_top_test;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic hit_o;
    logic [2:0] hit_idx_o;
    int failures = 0;
    int checked = 0;
    int seed = 42160;
    logic [31:0] m_base [8];
    logic [4:0] m_size [8];
    logic m_en [8];
    logic [2:0] m_idx = 3'h0;
    logic [31:0] b, a;
    logic [4:0] s;
    logic [2:0] i;
    logic e;

    pab_top u_pab_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .hit_o(hit_o), .hit_idx_o(hit_idx_o));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // Writes keep the model in step; a gap cycle follows so no strobe is driven twice at once.
    task automatic reg_write(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= ad;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        if (ad == pab_pkg::OFF_AREA_INDEX) m_idx = d[2:0];
        if (ad == pab_pkg::OFF_AREA_BASE) begin
            if (d[4]) m_idx = d[2:0];
            m_base[m_idx] = d & 32'hFFFF_FFE0;
        end
        if (ad == pab_pkg::OFF_ATTR_SIZE) begin
            m_size[m_idx] = d[5:1];
            m_en[m_idx] = d[0];
        end
    endtask

    task automatic reg_read(input logic [7:0] ad, input logic [31:0] exp, input string name);
        @(posedge clk_i);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(name, exp, reg_rdata_o);
    endtask

    function automatic logic [3:0] exp_hit(input logic [31:0] ad);
        for (int k = 0; k < 8; k++) begin
            if (m_en[k] && (m_size[k] == 5'h1F || (ad >> (m_size[k] + 1)) ==
                (m_base[k] >> (m_size[k] + 1)))) return {k[2:0], 1'b1};
        end
        return 4'h0;
    endfunction

    // Lookup result is settled one edge after the check address is taken.
    task automatic look(input logic [31:0] ad);
        logic [3:0] x;
        x = exp_hit(ad);
        reg_write(pab_pkg::OFF_CHECK_ADDR, ad);
        repeat (2) @(posedge clk_i);
        #1;
        chk("hit", {31'h0, x[0]}, {31'h0, hit_o});
        chk("hit_idx", {29'h0, x[3:1]}, {29'h0, hit_idx_o});
        reg_read(pab_pkg::OFF_CHECK_RESULT, {28'h0, x}, "result");
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        repeat (40000) @(posedge clk_i);
        failures++;
        conclude();
    end

    initial begin
        for (int k = 0; k < 8; k++) begin
            m_base[k] = 32'h0000_0000;
            m_size[k] = 5'h00;
            m_en[k] = 1'b0;
        end
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        reg_read(pab_pkg::OFF_AREA_BASE, 32'h0000_0000, "base_reset");
        reg_read(pab_pkg::OFF_ATTR_SIZE, 32'h0000_0000, "attr_reset");
        reg_write(pab_pkg::OFF_AREA_BASE, 32'h0001_0012);
        reg_read(pab_pkg::OFF_AREA_INDEX, 32'h0000_0002, "index");
        reg_read(pab_pkg::OFF_AREA_BASE, 32'h0001_0002, "base");
        reg_write(pab_pkg::OFF_ATTR_SIZE, 32'h0000_001F);
        look(32'h0001_FFFF);
        look(32'h0002_0000);
        look(32'h0000_FFFF);
        reg_write(pab_pkg::OFF_AREA_BASE, 32'h0003_0005);
        reg_read(pab_pkg::OFF_AREA_INDEX, 32'h0000_0002, "index_kept");
        look(32'h0003_8000);
        reg_write(pab_pkg::OFF_ATTR_SIZE, 32'h0000_001E);
        look(32'h0003_8000);
        reg_write(pab_pkg::OFF_ATTR_SIZE, 32'h0000_003F);
        look(32'hFFFF_FFFF);
        look(32'h0000_0000);
        // Smallest area at index 0 sits inside the full map area; the lower index must win.
        reg_write(pab_pkg::OFF_AREA_BASE, 32'h0000_0110);
        reg_write(pab_pkg::OFF_ATTR_SIZE, 32'h0000_0009);
        look(32'h0000_011F);
        look(32'h0000_0120);
        reg_read(pab_pkg::OFF_CHECK_ADDR, 32'h0000_0120, "check_addr");
        reg_write(pab_pkg::OFF_AREA_INDEX, 32'h0000_0002);
        reg_read(pab_pkg::OFF_ATTR_SIZE, 32'h0000_003F, "attr_by_index");
        reg_read(pab_pkg::OFF_AREA_BASE, 32'h0003_0002, "base_by_index");
        reg_write(8'h14, 32'hFFFF_FFFF);
        reg_read(8'h14, 32'h0000_0000, "unmapped");
        // Sizes stay at 4 or above and bases are aligned, as software must keep them.
        for (int n = 0; n < 40; n++) begin
            i = 3'($random(seed));
            s = 5'(4 + ($unsigned($random(seed)) % 28));
            b = $random(seed) & (32'hFFFF_FFFF << (s + 1));
            e = 1'($random(seed));
            reg_write(pab_pkg::OFF_AREA_BASE, b | 32'h0000_0010 | {29'h0, i});
            reg_write(pab_pkg::OFF_ATTR_SIZE, {26'h0, s, e});
            reg_read(pab_pkg::OFF_ATTR_SIZE, {26'h0, s, e}, "attr");
            reg_read(pab_pkg::OFF_AREA_BASE, b | {29'h0, i}, "base_rand");
            a = b | ($random(seed) & ~(32'hFFFF_FFFF << (s + 1)));
            look(a);
            look($random(seed));
        end
        conclude();
    end
endmodule // pab_top_test
